/* src/spsd_pkg.sv */
package spsd_pkg;
	// Word widths of the serial frame
	localparam int SPSD_SW_W = 7;
	localparam int SPSD_MN_W = 10;
	localparam int SPSD_RF_W = 11;
	// Whole frame length in serial clock edges
	localparam int SPSD_FRAME_W = SPSD_SW_W + SPSD_MN_W + SPSD_RF_W;
	localparam int SPSD_SHORT_W = SPSD_SW_W + SPSD_MN_W;
	// Edge counter width; long enough that one frame never wraps it
	localparam int SPSD_EC_W = 10;
	localparam logic [SPSD_EC_W-1:0] SPSD_FULL_CNT = 10'h01c;
	// Lowest legal main and reference values
	localparam logic [SPSD_MN_W-1:0] SPSD_MN_MIN = 10'h003;
	localparam logic [SPSD_RF_W-1:0] SPSD_RF_MIN = 11'h003;
	// Reset values of the counter latches
	localparam logic [SPSD_SW_W-1:0] SPSD_SW_RST = 7'h00;
	localparam logic [SPSD_MN_W-1:0] SPSD_MN_RST = 10'h003;
	localparam logic [SPSD_RF_W-1:0] SPSD_RF_RST = 11'h003;
	// Synchroniser depth
	localparam int SPSD_SYNC_STAGES = 2;
endpackage

/* src/spsd_sync.sv */
`timescale 1ns/1ns
// Multi-bit two-flop synchroniser; bits must be gray coded or quasi-static
module spsd_sync
	import spsd_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Asynchronous level in, synchronised level out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	// First stage is read only by the second stage
	logic [WIDTH-1:0] meta_q;

	// Two flops in series
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

/* src/spsd_top.sv */
`timescale 1ns/1ns
module spsd_top
	import spsd_pkg::*;
(
	// System clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Serial programming link
	input wire logic ser_clk_i,
	input wire logic ser_data_i,
	input wire logic ser_en_i,
	// Divider inputs from pins
	input wire logic prescaler_i,
	input wire logic osc_i,
	// Divider outputs
	output logic prescaler_modulus_select_o,
	output logic ref_div_o,
	output logic var_div_o
);
	// Link-domain shift register and free-running edge count
	logic [SPSD_FRAME_W-1:0] sr_q;
	logic [SPSD_EC_W-1:0] ec_bin_q;
	logic [SPSD_EC_W-1:0] ec_gray_q;
	logic [SPSD_EC_W-1:0] ec_bin_next;

	// Synchronised copies in the system domain
	logic en_s;
	logic psc_s;
	logic osc_s;
	logic [SPSD_EC_W-1:0] ec_gray_s;
	logic en_q;
	logic psc_q;
	logic osc_q;

	// Latches and edge count at the previous transfer
	logic [SPSD_SW_W-1:0] sw_lat_q;
	logic [SPSD_MN_W-1:0] mn_lat_q;
	logic [SPSD_RF_W-1:0] rf_lat_q;
	logic [SPSD_EC_W-1:0] ec_last_q;

	// Divider counters
	logic [SPSD_SW_W-1:0] sw_cnt_q;
	logic [SPSD_MN_W-1:0] mn_cnt_q;
	logic [SPSD_RF_W:0] rf_cnt_q;

	// Link logic: serial clock falling edge, only while enabled
	assign ec_bin_next = ec_bin_q + SPSD_EC_W'(1'b1);
	always_ff @(negedge ser_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sr_q <= '0;
			ec_bin_q <= '0;
			ec_gray_q <= '0;
		end
		else if (ser_en_i)
		begin
			// Shift in MSB first; pin level is the bit value
			sr_q <= {sr_q[SPSD_FRAME_W-2:0], ser_data_i};
			ec_bin_q <= ec_bin_next;
			// Gray form so the count can cross safely
			ec_gray_q <= ec_bin_next ^ (ec_bin_next >> 1);
		end
	end

	// Enable, gray count and divider pins into the system clock
	spsd_sync #(.WIDTH(SPSD_EC_W + 3)) u_sync
	(
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.async_i({ec_gray_q, ser_en_i, prescaler_i, osc_i}),
		.sync_o({ec_gray_s, en_s, psc_s, osc_s})
	);

	// Gray back to binary
	function automatic logic [SPSD_EC_W-1:0] gray2bin(
		input logic [SPSD_EC_W-1:0] g);
		logic [SPSD_EC_W-1:0] b;
		b = '0;
		// Top bit passes straight; each lower bit folds in the one above
		b[SPSD_EC_W-1] = g[SPSD_EC_W-1];
		for (int i = SPSD_EC_W - 2; i >= 0; i--)
			b[i] = g[i] ^ b[i+1];
		return b;
	endfunction

	// Decode of edges, frame length and word positions
	wire en_fall = en_q & ~en_s;
	wire psc_rise = psc_s & ~psc_q;
	wire osc_rise = osc_s & ~osc_q;
	wire [SPSD_EC_W-1:0] ec_now = gray2bin(ec_gray_s);
	wire [SPSD_EC_W-1:0] ec_delta = ec_now - ec_last_q;
	wire frame_full = ec_delta >= SPSD_FULL_CNT;
	// Swallow and main sit lower when no reference word followed
	wire [SPSD_SHORT_W-1:0] am_word = frame_full ?
		sr_q[SPSD_FRAME_W-1:SPSD_RF_W] : sr_q[SPSD_SHORT_W-1:0];
	wire [SPSD_SW_W-1:0] sw_new = am_word[SPSD_SHORT_W-1:SPSD_MN_W];
	wire [SPSD_MN_W-1:0] mn_new = am_word[SPSD_MN_W-1:0];
	wire [SPSD_RF_W-1:0] rf_new = sr_q[SPSD_RF_W-1:0];
	// Values below the minimum run at the minimum
	wire [SPSD_MN_W-1:0] mn_eff = (mn_lat_q < SPSD_MN_MIN) ?
		SPSD_MN_MIN : mn_lat_q;
	wire [SPSD_RF_W-1:0] rf_eff = (rf_lat_q < SPSD_RF_MIN) ?
		SPSD_RF_MIN : rf_lat_q;
	// Reference terminal count is twice the programmed value less one
	wire [SPSD_RF_W:0] rf_term = {rf_eff, 1'b0} - (SPSD_RF_W+1)'(1'b1);
	wire mn_done = psc_rise & (mn_cnt_q == SPSD_MN_W'(1'b1));
	wire rf_done = osc_rise & (rf_cnt_q == rf_term);

	// Edge history of synchronised levels
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			en_q <= 1'b0;
			psc_q <= 1'b0;
			osc_q <= 1'b0;
		end
		else
		begin
			en_q <= en_s;
			psc_q <= psc_s;
			osc_q <= osc_s;
		end
	end

	// Transfer into the counter latches on enable fall
	// Shift register is quiet here: enable is low, no edges arrive
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sw_lat_q <= SPSD_SW_RST;
			mn_lat_q <= SPSD_MN_RST;
			rf_lat_q <= SPSD_RF_RST;
			ec_last_q <= '0;
		end
		else if (en_fall)
		begin
			sw_lat_q <= sw_new;
			mn_lat_q <= mn_new;
			ec_last_q <= ec_now;
			// Reference kept on short frames against clock glitches
			if (frame_full)
				rf_lat_q <= rf_new;
		end
	end

	// Swallow and main counters stepped by synchronised prescaler rises
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sw_cnt_q <= SPSD_SW_RST;
			mn_cnt_q <= SPSD_MN_RST;
			prescaler_modulus_select_o <= 1'b1;
			var_div_o <= 1'b0;
		end
		else if (en_fall)
		begin
			// Restart the cycle with the new words
			sw_cnt_q <= sw_new;
			mn_cnt_q <= (mn_new < SPSD_MN_MIN) ? SPSD_MN_MIN : mn_new;
			prescaler_modulus_select_o <= (sw_new == '0);
			var_div_o <= 1'b0;
		end
		else if (mn_done)
		begin
			// Main finished: both reload, new count cycle
			sw_cnt_q <= sw_lat_q;
			mn_cnt_q <= mn_eff;
			prescaler_modulus_select_o <= (sw_lat_q == '0);
			var_div_o <= 1'b1;
		end
		else if (psc_rise)
		begin
			mn_cnt_q <= mn_cnt_q - SPSD_MN_W'(1'b1);
			var_div_o <= 1'b0;
			if (sw_cnt_q != '0)
			begin
				sw_cnt_q <= sw_cnt_q - SPSD_SW_W'(1'b1);
				// Swallow done: switch prescaler modulus
				if (sw_cnt_q == SPSD_SW_W'(1'b1))
					prescaler_modulus_select_o <= 1'b1;
			end
		end
		else
			var_div_o <= 1'b0;
	end

	// Reference counter on oscillator edges
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rf_cnt_q <= '0;
			ref_div_o <= 1'b0;
		end
		else if (en_fall)
		begin
			rf_cnt_q <= '0;
			ref_div_o <= 1'b0;
		end
		else if (rf_done)
		begin
			rf_cnt_q <= '0;
			ref_div_o <= 1'b1;
		end
		else
		begin
			if (osc_rise)
				rf_cnt_q <= rf_cnt_q + (SPSD_RF_W+1)'(1'b1);
			ref_div_o <= 1'b0;
		end
	end

	// Modulus select: low while swallow counts, high for the rest
	// (a zero swallow word skips the low phase entirely)
	// Checks in the system domain
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_transfer;
		en_fall |=> sw_lat_q == $past(sw_new) && mn_lat_q == $past(mn_new);
	endproperty
	a_transfer: assert property (p_transfer)
		else $error("latches not loaded on enable fall");

	property p_short_keep;
		en_fall && !frame_full |=> $stable(rf_lat_q);
	endproperty
	a_short_keep: assert property (p_short_keep)
		else $error("reference latch changed on short frame");

	property p_full_load;
		en_fall && frame_full |=> rf_lat_q == $past(rf_new);
	endproperty
	a_full_load: assert property (p_full_load)
		else $error("reference latch not loaded on full frame");

	property p_resync;
		en_fall |=> rf_cnt_q == '0 && !ref_div_o && !var_div_o;
	endproperty
	a_resync: assert property (p_resync)
		else $error("dividers not resynchronised");

	property p_mod_swallow;
		prescaler_modulus_select_o == (sw_cnt_q == '0);
	endproperty
	a_mod_swallow: assert property (p_mod_swallow)
		else $error("modulus switched before swallow finished");

	property p_main_end;
		mn_done && !en_fall |=> var_div_o && mn_cnt_q == mn_eff
			&& sw_cnt_q == sw_lat_q;
	endproperty
	a_main_end: assert property (p_main_end)
		else $error("main end did not restart the cycle");

	property p_ref_end;
		rf_done && !en_fall |=> ref_div_o ##1 !ref_div_o;
	endproperty
	a_ref_end: assert property (p_ref_end)
		else $error("reference pulse wrong");

	property p_main_range;
		mn_cnt_q != '0 && mn_cnt_q <= mn_eff && rf_cnt_q <= rf_term;
	endproperty
	a_main_range: assert property (p_main_range)
		else $error("counter outside legal range");

	// Checks in the link domain
	property p_ignore;
		@(negedge ser_clk_i) disable iff (!rst_n_i)
			!ser_en_i |=> $stable(sr_q);
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("shift register moved while disabled");

	property p_shift;
		@(negedge ser_clk_i) disable iff (!rst_n_i)
			ser_en_i |=> sr_q[0] == $past(ser_data_i);
	endproperty
	a_shift: assert property (p_shift)
		else $error("serial bit not shifted in");

	c_full: cover property (en_fall && frame_full);
	c_short: cover property (en_fall && !frame_full);
	c_var: cover property (var_div_o);
	c_ref: cover property (ref_div_o);
endmodule

/* verification/spsd_ser_master.sv */
`timescale 1ns/1ns
// Controller model driving the three-wire programming port
module spsd_ser_master
(
	// Link pins toward the block
	output logic ser_clk_o,
	output logic ser_data_o,
	output logic ser_en_o
);
	// Idle: clock parked high so enable may move at any time
	initial
	begin
		ser_clk_o = 1'b1;
		ser_data_o = 1'b0;
		ser_en_o = 1'b0;
	end
	// Last n bits of w, MSB first, one bit per falling clock
	task automatic send(input logic [27:0] w, input int n);
		int i;
		ser_en_o = 1'b1;
		#60;
		for (i = n - 1; i >= 0; i--)
		begin
			ser_data_o = w[i];
			#15 ser_clk_o = 1'b0;
			#15 ser_clk_o = 1'b1;
		end
		// Data no longer held once the frame is over
		#15 ser_data_o = ~ser_data_o;
		#15 ser_en_o = 1'b0;
		#60;
	endtask
	// Clock and data activity while enable stays low
	task automatic glitch(input int n);
		int i;
		for (i = 0; i < n; i++)
		begin
			ser_data_o = ~ser_data_o;
			#15 ser_clk_o = 1'b0;
			#15 ser_clk_o = 1'b1;
		end
	endtask
endmodule

/* verification/spsd_top_tb.sv */
`timescale 1ns/1ns
module spsd_top_tb;
	import spsd_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic prescaler_i = 1'b0;
	logic osc_i = 1'b0;
	wire ser_clk;
	wire ser_data;
	wire ser_en;
	wire prescaler_modulus_select_o;
	wire ref_div_o;
	wire var_div_o;
	int n_errors = 0;
	int cmp_count = 0;
	// Divider inputs step on falling edges, slow enough for the syncs
	always #5 sys_clk_i = ~sys_clk_i;
	always #40 prescaler_i = ~prescaler_i;
	always #30 osc_i = ~osc_i;
	spsd_ser_master pm (
		.ser_clk_o(ser_clk),
		.ser_data_o(ser_data),
		.ser_en_o(ser_en)
	);
	spsd_top uut (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ser_clk_i(ser_clk),
		.ser_data_i(ser_data),
		.ser_en_i(ser_en),
		.prescaler_i(prescaler_i),
		.osc_i(osc_i),
		.prescaler_modulus_select_o(prescaler_modulus_select_o),
		.ref_div_o(ref_div_o),
		.var_div_o(var_div_o)
	);
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Input rises over one whole output period, split by select level
	task automatic span(input bit use_ref, output int lo, output int hi);
		int k;
		int p;
		logic pv;
		lo = 0;
		hi = 0;
		for (p = 0; p < 2; p++)
		begin
			for (k = 0; k < 50000; k++)
			begin
				pv = use_ref ? osc_i : prescaler_i;
				@(posedge sys_clk_i);
				#1;
				// Select seen at the raw edge, before that edge takes effect
				if (p == 1 && (use_ref ? osc_i : prescaler_i) && !pv)
				begin
					if (prescaler_modulus_select_o === 1'b0)
						lo++;
					else
						hi++;
				end
				if ((use_ref ? ref_div_o : var_div_o) === 1'b1)
					break;
			end
			if (k == 50000)
			begin
				n_errors++;
				wrap_up();
			end
		end
	endtask
	// Expected period split and reference ratio after a transfer
	task automatic expect_div(input int a, input int m, input int r);
		int lo;
		int hi;
		repeat (10) @(negedge sys_clk_i);
		span(1'b0, lo, hi);
		check("swallow phase", lo, a);
		check("main phase", hi, m - a);
		span(1'b1, lo, hi);
		check("reference ratio", lo + hi, 2 * r);
	endtask
	// Full frame loads all three words
	task automatic t_full;
		pm.send({7'h01, 10'h004, 11'h005}, 28);
		expect_div(1, 4, 5);
		$display("test full frame done");
	endtask
	// Ignored clocks, then a short frame; reference must stay
	task automatic t_short;
		pm.glitch(12);
		pm.send({11'h000, 7'h00, 10'h003}, 17);
		expect_div(0, 3, 5);
		$display("test short frame done");
	endtask
	// Largest swallow and reference values
	task automatic t_edge;
		pm.send({7'h7f, 10'h082, 11'h7ff}, 28);
		expect_div(127, 130, 2047);
		$display("test range edges done");
	endtask
	initial
	begin
		repeat (16) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		t_full();
		t_short();
		t_edge();
		wrap_up();
	end
endmodule
